// [verilog/sps_socket_status.sv]
// Purpose: socket present-state register with event, force and control registers
// Assumes: MCLK 50 MHz, RESET_N synchronous active low, card pins asynchronous
// Notes: read data valid only in the cycle after RD; unmapped reads return zero
`timescale 1ns/100ps
module sps_socket_status
	import sps_pkg::*;
#(
	parameter int INTERROGATE_CYCLES = SPS_INTERROGATE_CYCLES
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic DETECT_ONE_N,
	input wire logic DETECT_TWO_N,
	input wire logic STATUS_CHANGE,
	input wire logic READY_IRQ,
	input wire logic [1:0] VOLT_SENSE,
	input wire logic CYCLE_PENDING,
	output logic DETECT_DRIVE_EN,
	output logic SOCKET_POWER_ON
);
	logic [5:0] pins_sync;
	logic [1:0] detect_sync;
	logic status_sync;
	logic ready_sync;
	logic [1:0] vs_sync;
	logic busy;
	logic done;
	sps_card_s card_result;

	// Status state
	logic [3:0] card_volts;
	logic cardbus_type_present;
	logic sixteen_bit_type_present;
	logic unrecognised_card;
	logic invalid_power_request;
	logic removal_data_loss;
	logic socket_powered;
	logic [1:0] detect_level;
	logic status_change_level;
	logic ready_irq_level;
	logic [3:0] event_flags;
	logic [1:0] vcc_request;
	logic interrogate_start;
	logic [3:0] next_card_volts;
	logic next_cardbus;
	logic next_sixteen;
	logic next_unrecognised;
	logic next_invalid_req;
	logic next_data_loss;
	logic next_powered;
	logic [1:0] next_detect_level;
	logic next_status_level;
	logic next_ready_level;
	logic [3:0] next_event_flags;
	logic [1:0] next_vcc_request;
	logic next_interrogate_start;
	logic [31:0] next_rdata;
	logic [31:0] present_word;
	logic wr_force;
	logic wr_control;
	logic inserted;
	logic removed;
	logic voltage_reinterrogate;
	logic [3:0] event_set;
	logic [1:0] detect_tail;
	logic [1:0] next_detect_tail;
	logic detect_hold;

	sps_sync #(
		.WIDTH(6)
	) u_sync (
		.clk(MCLK),
		.reset_n(RESET_N),
		// Detect lines enter inverted so a cleared synchroniser reads as an empty socket
		.async_in({VOLT_SENSE, READY_IRQ, STATUS_CHANGE, ~DETECT_TWO_N, ~DETECT_ONE_N}),
		.sync_out(pins_sync)
	);

	assign detect_sync = ~pins_sync[1:0];
	assign status_sync = pins_sync[2];
	assign ready_sync = pins_sync[3];
	assign vs_sync = pins_sync[5:4];

	sps_interrogate #(
		.CYCLES(INTERROGATE_CYCLES)
	) u_interrogate (
		.clk(MCLK),
		.reset_n(RESET_N),
		.start(interrogate_start),
		.vs(vs_sync),
		.busy(busy),
		.done(done),
		.card(card_result)
	);

	always_comb begin
		wr_force = WR && (ADDR == SPS_OFS_FORCE);
		wr_control = WR && (ADDR == SPS_OFS_CONTROL);
		voltage_reinterrogate = wr_force && WDATA[SPS_FRC_VTEST];
		// Hold also covers the synchroniser delay after the drive ends
		detect_hold = busy || (detect_tail != 2'h0);
		// Both detect lines low marks a seated card
		inserted = !detect_hold && (detect_sync == 2'b00) && (detect_level != 2'b00);
		removed = !detect_hold && (detect_sync != 2'b00) && (detect_level == 2'b00);
	end

	// Socket status state
	always_comb begin
		next_card_volts = card_volts;
		next_cardbus = cardbus_type_present;
		next_sixteen = sixteen_bit_type_present;
		next_unrecognised = unrecognised_card;
		next_invalid_req = invalid_power_request;
		next_data_loss = removal_data_loss;
		next_powered = socket_powered;
		next_vcc_request = vcc_request;
		next_interrogate_start = inserted || voltage_reinterrogate;
		next_ready_level = ready_sync;
		next_status_level = status_sync;
		next_detect_level = detect_hold ? detect_level : detect_sync;
		next_detect_tail = detect_tail;
		if (busy) begin
			next_detect_tail = SPS_DETECT_TAIL;
		end else if (detect_tail != 2'h0) begin
			next_detect_tail = detect_tail - 2'h1;
		end
		if (inserted) begin
			next_data_loss = 1'b0;
		end
		if (removed && CYCLE_PENDING) begin
			next_data_loss = 1'b1;
		end
		if (removed) begin
			next_powered = 1'b0;
		end
		if (done) begin
			next_card_volts = card_result.volts;
			next_cardbus = card_result.cardbus;
			next_sixteen = card_result.sixteen_bit;
			if (card_result.not_card) begin
				next_unrecognised = 1'b1;
			end else begin
				next_unrecognised = 1'b0;
			end
		end
		if (wr_control) begin
			next_vcc_request = WDATA[1:0];
			// Refuse a supply the card does not claim, leaving the socket off
			if (WDATA[1:0] == SPS_VCC_OFF) begin
				next_powered = 1'b0;
				next_invalid_req = 1'b0;
			end else if ((WDATA[1:0] == SPS_VCC_FIVE && card_volts[0])
				|| (WDATA[1:0] == SPS_VCC_THREE && card_volts[1])) begin
				next_powered = 1'b1;
				next_invalid_req = 1'b0;
			end else begin
				next_powered = 1'b0;
				next_invalid_req = 1'b1;
			end
		end
		// Force writes take priority over a finishing interrogation
		if (wr_force) begin
			next_card_volts = WDATA[SPS_PS_CARD_LO +: 4];
			next_invalid_req = WDATA[SPS_PS_BAD_REQ];
			next_data_loss = WDATA[SPS_PS_DATA_LOSS];
			next_unrecognised = WDATA[SPS_PS_NOT_CARD];
			next_cardbus = WDATA[SPS_PS_CARDBUS];
			next_sixteen = WDATA[SPS_PS_SIXTEEN];
		end
	end

	// Event flags: a hardware set in the clearing cycle survives
	always_comb begin
		event_set = '0;
		if (cardbus_type_present) begin
			event_set[SPS_EV_STATUS] = status_sync && !status_change_level;
		end else begin
			event_set[SPS_EV_STATUS] = status_sync != status_change_level;
		end
		event_set[SPS_EV_DETECT1] = next_detect_level[0] != detect_level[0];
		event_set[SPS_EV_DETECT2] = next_detect_level[1] != detect_level[1];
		event_set[SPS_EV_POWER] = next_powered != socket_powered;
		if (wr_force) begin
			event_set = event_set | WDATA[3:0];
		end
		next_event_flags = event_flags;
		if (WR && ADDR == SPS_OFS_EVENT) begin
			next_event_flags = event_flags & ~WDATA[3:0];
		end
		next_event_flags = next_event_flags | event_set;
	end

	// Read path
	always_comb begin
		present_word = '0;
		present_word[SPS_PS_SOCK_LO +: 4] = SPS_SOCK_CAPS;
		present_word[SPS_PS_CARD_LO +: 4] = card_volts;
		present_word[SPS_PS_BAD_REQ] = invalid_power_request;
		present_word[SPS_PS_DATA_LOSS] = removal_data_loss;
		present_word[SPS_PS_NOT_CARD] = unrecognised_card;
		present_word[SPS_PS_READY] = ready_irq_level;
		present_word[SPS_PS_CARDBUS] = cardbus_type_present;
		present_word[SPS_PS_SIXTEEN] = sixteen_bit_type_present;
		present_word[SPS_PS_POWERED] = socket_powered;
		present_word[SPS_PS_DETECT_LO +: 2] = detect_level;
		present_word[SPS_PS_STATUS] = status_change_level;
		next_rdata = '0;
		if (RD) begin
			case (ADDR)
				SPS_OFS_EVENT: next_rdata = {28'h0000000, event_flags};
				SPS_OFS_PRESENT: next_rdata = present_word;
				SPS_OFS_CONTROL: next_rdata = {30'h00000000, vcc_request};
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			card_volts <= '0;
			cardbus_type_present <= 1'b0;
			sixteen_bit_type_present <= 1'b0;
			unrecognised_card <= 1'b0;
			invalid_power_request <= 1'b0;
			removal_data_loss <= 1'b0;
			socket_powered <= 1'b0;
			SOCKET_POWER_ON <= 1'b0;
			detect_level <= 2'b11;
			status_change_level <= 1'b0;
			ready_irq_level <= 1'b0;
			event_flags <= '0;
			vcc_request <= SPS_VCC_OFF;
			interrogate_start <= 1'b0;
			DETECT_DRIVE_EN <= 1'b0;
			detect_tail <= '0;
			RDATA <= '0;
		end else begin
			card_volts <= next_card_volts;
			cardbus_type_present <= next_cardbus;
			sixteen_bit_type_present <= next_sixteen;
			unrecognised_card <= next_unrecognised;
			invalid_power_request <= next_invalid_req;
			removal_data_loss <= next_data_loss;
			socket_powered <= next_powered;
			SOCKET_POWER_ON <= next_powered;
			detect_level <= next_detect_level;
			status_change_level <= next_status_level;
			ready_irq_level <= next_ready_level;
			event_flags <= next_event_flags;
			vcc_request <= next_vcc_request;
			interrogate_start <= next_interrogate_start;
			DETECT_DRIVE_EN <= busy;
			detect_tail <= next_detect_tail;
			RDATA <= next_rdata;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);

	rsvd_zero_a: assert property (RD && ADDR == SPS_OFS_PRESENT |=>
		RDATA[SPS_PS_RSVD_HI:SPS_PS_RSVD_LO] == '0) else $error("reserved bits not zero");
	sock_caps_a: assert property (RD && ADDR == SPS_OFS_PRESENT |=>
		RDATA[31:28] == 4'h3) else $error("socket capability bits wrong");
	card_hold_a: assert property (!$past(done) && !$past(wr_force) |->
		$stable(card_volts) && $stable(cardbus_type_present)) else $error("card bits moved");
	detect_freeze_a: assert property (busy |=>
		detect_level == $past(detect_level)) else $error("detect changed while busy");
	ready_follow_a: assert property ($rose(READY_IRQ) ##1 READY_IRQ [*3] |->
		ready_irq_level) else $error("ready bit not following line");
	force_volts_a: assert property (wr_force |=>
		card_volts == $past(WDATA[13:10])) else $error("force voltage not loaded");
	vtest_start_a: assert property (voltage_reinterrogate && !busy |->
		##[2:3] busy) else $error("voltage test did not interrogate");
	cb_edge_a: assert property ($past(cardbus_type_present) && !$past(wr_force) &&
		$fell(status_change_level) && !$past(event_flags[0])
		|-> !event_flags[0]) else $error("cardbus falling edge set event");
	bad_req_a: assert property (wr_control && WDATA[1:0] != SPS_VCC_OFF && !wr_force
		&& !(WDATA[1:0] == SPS_VCC_FIVE && card_volts[0])
		&& !(WDATA[1:0] == SPS_VCC_THREE && card_volts[1])
		|=> invalid_power_request && !socket_powered) else $error("bad request not flagged");
	loss_set_a: assert property (removed && CYCLE_PENDING && !wr_force |=>
		removal_data_loss) else $error("data loss not flagged");

	insert_c: cover property (inserted ##[1:200] done);
	force_c: cover property (wr_force ##1 RD && ADDR == SPS_OFS_PRESENT);
	power_c: cover property (wr_control ##1 socket_powered);
	removal_c: cover property (removed && CYCLE_PENDING);
endmodule

// [include/sps_pkg.sv]
// Purpose: shared constants and types for the socket present-state block
// Assumes: 32-bit register port with byte offsets on an 8-bit address
// Notes: status word layout, event bits, control encodings, timing
package sps_pkg;
	// Register offsets
	localparam logic [7:0] SPS_OFS_EVENT = 8'h00;
	localparam logic [7:0] SPS_OFS_PRESENT = 8'h08;
	localparam logic [7:0] SPS_OFS_FORCE = 8'h0C;
	localparam logic [7:0] SPS_OFS_CONTROL = 8'h10;
	// Present-state field positions
	localparam int SPS_PS_SOCK_LO = 28;
	localparam int SPS_PS_RSVD_HI = 27;
	localparam int SPS_PS_RSVD_LO = 14;
	localparam int SPS_PS_CARD_LO = 10;
	localparam int SPS_PS_BAD_REQ = 9;
	localparam int SPS_PS_DATA_LOSS = 8;
	localparam int SPS_PS_NOT_CARD = 7;
	localparam int SPS_PS_READY = 6;
	localparam int SPS_PS_CARDBUS = 5;
	localparam int SPS_PS_SIXTEEN = 4;
	localparam int SPS_PS_POWERED = 3;
	localparam int SPS_PS_DETECT_LO = 1;
	localparam int SPS_PS_STATUS = 0;
	// Socket capability: no Y.Y or X.X supply, 3.3 V and 5 V present
	localparam logic [3:0] SPS_SOCK_CAPS = 4'h3;
	// Force register: voltage test bit; card bits share present positions, bits 3:0 set event flags
	localparam int SPS_FRC_VTEST = 14;
	// Event register bits
	localparam int SPS_EV_STATUS = 0;
	localparam int SPS_EV_DETECT1 = 1;
	localparam int SPS_EV_DETECT2 = 2;
	localparam int SPS_EV_POWER = 3;
	// Control register supply request encodings
	localparam logic [1:0] SPS_VCC_OFF = 2'h0;
	localparam logic [1:0] SPS_VCC_FIVE = 2'h1;
	localparam logic [1:0] SPS_VCC_THREE = 2'h2;
	// Interrogation window
	localparam int SPS_CLK_PERIOD_NS = 20;
	localparam int SPS_INTERROGATE_NS = 1000;
	localparam int SPS_INTERROGATE_CYCLES =
		(SPS_INTERROGATE_NS + SPS_CLK_PERIOD_NS - 1) / SPS_CLK_PERIOD_NS;

	// Edges after interrogation during which driven detect levels may still be in flight
	localparam logic [1:0] SPS_DETECT_TAIL = 2'h3;

	typedef enum {SPS_IDLE, SPS_DRIVE} sps_state_e;

	typedef struct packed {
		logic [3:0] volts;
		logic cardbus;
		logic sixteen_bit;
		logic not_card;
	} sps_card_s;

	// Voltage-sense strap pair to card identity
	function automatic sps_card_s sps_decode_card(input logic [1:0] vs);
		sps_card_s c;
		c = '0;
		case (vs)
			2'h3: begin
				c.sixteen_bit = 1'b1;
				c.volts = 4'h1;
			end
			2'h2: begin
				c.sixteen_bit = 1'b1;
				c.volts = 4'h3;
			end
			2'h1: begin
				c.cardbus = 1'b1;
				c.volts = 4'h2;
			end
			default: c.not_card = 1'b1;
		endcase
		return c;
	endfunction
endpackage

// [verilog/sps_sync.sv]
// Purpose: two-flop synchroniser for asynchronous socket pins
// Assumes: synchronous active-low reset
// Notes: only the second stage may be observed
`timescale 1ns/100ps
module sps_sync
	import sps_pkg::*;
#(
	parameter int WIDTH = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage;
	logic [WIDTH-1:0] next_stage;
	logic [WIDTH-1:0] next_sync_out;

	always_comb begin
		next_stage = async_in;
		next_sync_out = stage;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stage <= '0;
			sync_out <= '0;
		end else begin
			stage <= next_stage;
			sync_out <= next_sync_out;
		end
	end
endmodule

// [verilog/sps_interrogate.sv]
// Purpose: card identification sequence after insertion or a voltage test
// Assumes: start is a one-cycle pulse, vs already synchronised
// Notes: detect lines are driven for the whole window; result sampled at its end
`timescale 1ns/100ps
module sps_interrogate
	import sps_pkg::*;
#(
	parameter int CYCLES = SPS_INTERROGATE_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [1:0] vs,
	output logic busy,
	output logic done,
	output sps_card_s card
);
	sps_state_e state;
	sps_state_e next_state;
	logic [15:0] count;
	logic [15:0] next_count;
	logic next_done;
	sps_card_s next_card;

	always_comb begin
		next_state = state;
		next_count = count;
		next_done = 1'b0;
		next_card = card;
		case (state)
			SPS_IDLE: begin
				if (start) begin
					next_state = SPS_DRIVE;
					next_count = 16'(CYCLES - 1);
				end
			end
			SPS_DRIVE: begin
				if (count == 16'h0000) begin
					next_state = SPS_IDLE;
					next_done = 1'b1;
					next_card = sps_decode_card(vs);
				end else begin
					next_count = count - 16'h0001;
				end
			end
			default: next_state = SPS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= SPS_IDLE;
			count <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			card <= '0;
		end else begin
			state <= next_state;
			count <= next_count;
			busy <= (next_state == SPS_DRIVE);
			done <= next_done;
			card <= next_card;
		end
	end
endmodule

// [verif/sps_card_model.sv]
// Purpose: behavioural card standing in the socket
// Assumes: kind is the voltage-sense strap pair of the card
// Notes: detect_two_n bounces for four cycles once the controller starts driving the detect lines
`timescale 1ns/100ps
module sps_card_model
	import sps_pkg::*;
(
	input wire logic mclk,
	input wire logic inserted,
	input wire logic [1:0] kind,
	input wire logic drive_en,
	output logic detect_one_n,
	output logic detect_two_n,
	output logic [1:0] volt_sense
);
	logic prev_en = 1'b0;
	logic [2:0] bounce = 3'h0;
	always @(posedge mclk) begin
		prev_en <= drive_en;
		// Driven detect line looks like a removal for a few cycles
		if (drive_en && !prev_en) begin
			bounce <= 3'h4;
		end else if (bounce != 3'h0) begin
			bounce <= bounce - 3'h1;
		end
	end
	assign detect_one_n = !inserted;
	assign detect_two_n = !inserted || (bounce != 3'h0);
	// Empty socket has no straps: show a changing value, not the last one
	assign volt_sense = inserted ? kind : ~kind;
endmodule

// [verif/test_sps_socket_status.sv]
// Purpose: self-checking bench for the socket present-state register
// Assumes: shortened interrogation window, card model on the socket pins
// Notes: rows cover every strap code; awkward cases follow the loop
`timescale 1ns/100ps
module test_sps_socket_status
	import sps_pkg::*;
;
	typedef struct packed {
		logic [1:0] vs;
		logic sts;
		logic rdy;
		logic [31:0] word;
	} sps_row_s;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic sts = 1'b0;
	logic rdy = 1'b0;
	logic pending = 1'b0;
	logic inserted = 1'b0;
	logic [1:0] kind = 2'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic [31:0] d;
	logic det1_n;
	logic det2_n;
	logic drive_en;
	logic power_on;
	logic [1:0] vs;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	// Not-a-card first so the next valid card must clear bit 7
	sps_row_s rows [4] = '{
		'{2'h0, 1'b1, 1'b0, 32'h3000_0081},
		'{2'h3, 1'b0, 1'b1, 32'h3000_0450},
		'{2'h2, 1'b1, 1'b1, 32'h3000_0C51},
		'{2'h1, 1'b0, 1'b0, 32'h3000_0820}
	};

	always #10 mclk = ~mclk;

	sps_socket_status #(.INTERROGATE_CYCLES(12)) sps_socket_status_inst (
		.MCLK(mclk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr_en),
		.RD(rd_en), .RDATA(rdata), .DETECT_ONE_N(det1_n), .DETECT_TWO_N(det2_n),
		.STATUS_CHANGE(sts), .READY_IRQ(rdy), .VOLT_SENSE(vs), .CYCLE_PENDING(pending),
		.DETECT_DRIVE_EN(drive_en), .SOCKET_POWER_ON(power_on)
	);
	sps_card_model sps_card_model_inst (
		.mclk(mclk), .inserted(inserted), .kind(kind), .drive_en(drive_en),
		.detect_one_n(det1_n), .detect_two_n(det2_n), .volt_sense(vs)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 v = rdata;
		// Return on a rising edge so following stimulus stays edge-aligned
		@(posedge mclk);
	endtask
	task automatic wait_en(input logic v);
		int i;
		for (i = 0; i < 40 && drive_en !== v; i++) begin
			@(posedge mclk);
		end
		chk({31'h0, drive_en}, {31'h0, v});
	endtask
	task automatic settle();
		repeat (8) @(posedge mclk);
	endtask
	task automatic wait_card();
		wait_en(1'b1);
		// Read while the bounce would have reached the detect bits
		repeat (2) @(posedge mclk);
		bus_rd(SPS_OFS_PRESENT, d);
		chk({30'h0, d[2:1]}, 32'h0);
		wait_en(1'b0);
		repeat (3) @(posedge mclk);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Full run is a few hundred cycles; the ceiling leaves wide margin
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			final_report();
		end
	end

	initial begin
		int i;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		bus_rd(SPS_OFS_PRESENT, d);
		chk(d, 32'h3000_0006);
		chk({31'h0, power_on}, 32'h0);
		bus_rd(8'h04, d);
		chk(d, 32'h0);
		bus_rd(SPS_OFS_FORCE, d);
		chk(d, 32'h0);
		for (i = 0; i < 4; i++) begin
			inserted <= 1'b0;
			settle();
			kind <= rows[i].vs;
			sts <= rows[i].sts;
			rdy <= rows[i].rdy;
			inserted <= 1'b1;
			wait_card();
			bus_rd(SPS_OFS_PRESENT, d);
			chk(d, rows[i].word);
		end
		// CardBus card: only a rising status line raises the event
		sts <= 1'b1;
		settle();
		bus_wr(SPS_OFS_EVENT, 32'h0000_000F);
		sts <= 1'b0;
		settle();
		bus_rd(SPS_OFS_EVENT, d);
		chk(d, 32'h0);
		sts <= 1'b1;
		settle();
		bus_rd(SPS_OFS_EVENT, d);
		chk(d, 32'h1);
		bus_wr(SPS_OFS_CONTROL, {30'h0, SPS_VCC_THREE});
		settle();
		bus_rd(SPS_OFS_PRESENT, d);
		chk(d, 32'h3000_0829);
		chk({31'h0, power_on}, 32'h1);
		bus_wr(SPS_OFS_CONTROL, {30'h0, SPS_VCC_FIVE});
		settle();
		bus_rd(SPS_OFS_PRESENT, d);
		chk(d, 32'h3000_0A21);
		bus_wr(SPS_OFS_CONTROL, {30'h0, SPS_VCC_OFF});
		settle();
		bus_rd(SPS_OFS_PRESENT, d);
		chk(d, 32'h3000_0821);
		// Straps change with no insertion: card bits must hold
		kind <= 2'h3;
		settle();
		bus_rd(SPS_OFS_PRESENT, d);
		chk(d, 32'h3000_0821);
		bus_wr(SPS_OFS_FORCE, 32'h1 << SPS_FRC_VTEST);
		wait_card();
		bus_rd(SPS_OFS_PRESENT, d);
		chk(d, 32'h3000_0411);
		// 16-bit card: the falling edge counts too
		bus_wr(SPS_OFS_EVENT, 32'h0000_000F);
		sts <= 1'b0;
		settle();
		bus_rd(SPS_OFS_EVENT, d);
		chk(d & 32'h1, 32'h1);
		bus_wr(SPS_OFS_FORCE, 32'h0000_2BBF);
		bus_rd(SPS_OFS_PRESENT, d);
		chk(d, 32'h3000_2BB0);
		bus_rd(SPS_OFS_EVENT, d);
		chk(d & 32'hF, 32'hF);
		// Removal with a cycle outstanding flags data loss
		bus_wr(SPS_OFS_FORCE, 32'h0);
		pending <= 1'b1;
		inserted <= 1'b0;
		settle();
		bus_rd(SPS_OFS_PRESENT, d);
		chk(d, 32'h3000_0106);
		final_report();
	end
endmodule
